// ===== dcff_link_model.sv
// writer and reader on their own free-running link clocks
`timescale 1ns/1ps
module dcff_link_model (
  input wire logic clk, // system clock
  input wire logic [8:0] dataOut, // read data
  output logic wrClk, // writer clock
  output logic rdClk, // reader clock
  output logic wrEn1N, // write enable one
  output logic wrEn2Load, // enable two or load
  output logic [8:0] dataIn, // write data
  output logic rdEn1N, // read enable one
  output logic rdEn2N // read enable two
);
  initial begin
    wrClk = 1'b0;
    #7;
    forever #100 wrClk = ~wrClk;
  end
  initial begin
    rdClk = 1'b0;
    #61;
    forever #100 rdClk = ~rdClk;
  end
  // idle levels; strap high by default
  initial begin
    wrEn1N = 1'b1;
    wrEn2Load = 1'b1;
    dataIn = 9'h000;
    rdEn1N = 1'b1;
    rdEn2N = 1'b1;
  end
  task automatic setStrap(input logic lvl);
    wrEn2Load = lvl;
  endtask
  // one word per write clock rise, held over the whole high phase
  task automatic push(input logic [8:0] d, input logic ld);
    @(negedge wrClk);
    @(negedge clk);
    wrEn1N = 1'b0;
    wrEn2Load = ~ld;
    dataIn = d;
    @(negedge wrClk);
    @(negedge clk);
    wrEn1N = 1'b1;
    wrEn2Load = 1'b1;
    dataIn = ~d; // released bus shows the inverse, not stale data
  endtask
  // one read per read clock rise
  task automatic pop(output logic [8:0] d);
    @(negedge rdClk);
    @(negedge clk);
    rdEn1N = 1'b0;
    rdEn2N = 1'b0;
    @(negedge rdClk);
    @(negedge clk);
    rdEn1N = 1'b1;
    rdEn2N = 1'b1;
    d = dataOut;
  endtask
  // keep reading on every read clock rise while on
  task automatic holdRead(input logic on);
    rdEn1N = ~on;
    rdEn2N = ~on;
  endtask
endmodule

// ===== dcff_pkg.sv
// constants, types and pin bundles for the dual-clock flag-timed buffer
// How it works
// [RULE_01] full releases now only after skew-one settle
// [RULE_02] empty releases now only after skew-one settle
// [RULE_03] almost-empty changes after skew-two settle
// [RULE_04] link clocks may toggle throughout reset
// [RULE_05] data low when driven, released otherwise; the code holds dataOutOeN high through all of reset, whatever outDriveN
// [RULE_06] strap at reset picks enable or load
// [RULE_07] first word read the cycle after release
// [RULE_08] empty-boundary latency bounded by skew settling
// [RULE_09] almost-empty low holding offset minus one words
// [RULE_10] almost-full low holding full minus offset-one
// [RULE_11] refuse writes when full, reads when empty
// [RULE_12] flags update on own side's edges only
package dcff_pkg;

  // storage shape
  localparam int DATA_W = 9;
  localparam int ADDR_W = 14;
  localparam int PTR_W = 15;
  localparam logic [PTR_W-1:0] FULL_COUNT = 15'h4000;

  // programmable offset layout, loaded through the nine-bit data pins
  localparam int OFS_W = 14;
  localparam int OFS_LO_W = 9;
  localparam int OFS_HI_W = 5;
  localparam logic [OFS_W-1:0] OFS_DEFAULT = 14'h0007;

  // timing: system clock period and the two skew minimums
  localparam int CLK_PERIOD_PS = 25000;
  localparam int SKEW1_NS = 5;
  localparam int SKEW2_NS = 10;
  localparam int SKEW1_RAW = (SKEW1_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SKEW2_RAW = (SKEW2_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int AGE_W = 4;
  localparam logic [AGE_W-1:0] SKEW1_CNT = AGE_W'((SKEW1_RAW < 1) ? 1 : SKEW1_RAW);
  localparam logic [AGE_W-1:0] SKEW2_CNT = AGE_W'((SKEW2_RAW < 1) ? 1 : SKEW2_RAW);

  // reset values of the registered outputs (flags are active low)
  localparam logic [DATA_W-1:0] DATA_RESET = 9'h000;
  localparam logic FLAG_ASSERTED = 1'b0;
  localparam logic FLAG_RELEASED = 1'b1;

  // order in which load strobes fill the offset registers
  typedef enum logic [1:0] {
    LOAD_AE_LO,
    LOAD_AE_HI,
    LOAD_AF_LO,
    LOAD_AF_HI
  } dcff_load_e;

  // every pin that crosses into the system clock domain
  typedef struct packed {
    logic wrClk;
    logic rdClk;
    logic wrEn1N;
    logic wrEn2Load;
    logic rdEn1N;
    logic rdEn2N;
    logic outDriveN;
    logic [DATA_W-1:0] data;
  } dcff_pins_s;

  localparam int PINS_W = $bits(dcff_pins_s);

  // the four status indicators, all active low
  typedef struct packed {
    logic emptyN;
    logic almostEmptyN;
    logic fullN;
    logic almostFullN;
  } dcff_flags_s;

endpackage

// ===== dcff_settle.sv
// copy of the far side's pointer that follows only once it has stood long enough
`timescale 1ns/1ps
module dcff_settle #(
  parameter logic [dcff_pkg::AGE_W-1:0] CNT = 4'h1
) (
  input wire logic clk, // system clock
  input wire logic resetn, // asynchronous reset, active low
  input wire logic moved, // pulse: pointer advances at this edge
  input wire logic [dcff_pkg::PTR_W-1:0] ptr, // live far-side pointer
  output logic [dcff_pkg::PTR_W-1:0] settled // pointer as seen by this side
);

  logic [dcff_pkg::AGE_W-1:0] age;
  logic [dcff_pkg::AGE_W-1:0] next_age;
  logic [dcff_pkg::PTR_W-1:0] next_settled;

  // age counts cycles since the last move and saturates at the skew count
  always_comb begin
    next_age = age;
    next_settled = settled;
    if (moved) begin
      next_age = '0;
    end else if (age != CNT) begin
      next_age = age + 1'b1;
    end else begin
      next_settled = ptr;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      age <= CNT;
      settled <= '0;
    end else begin
      age <= next_age;
      settled <= next_settled;
    end
  end

endmodule

// ===== dcff_sync.sv
// two-stage synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module dcff_sync #(
  parameter int W = 1
) (
  input wire logic clk, // system clock
  input wire logic [W-1:0] din, // asynchronous pin levels
  output logic [W-1:0] dout // levels after two flops
);

  logic [W-1:0] stage1;

  // no reset on purpose: the strap level must be visible right at reset release
  always_ff @(posedge clk) begin
    stage1 <= din;
    dout <= stage1;
  end

endmodule

// ===== dcff_top.sv
// nine-bit buffer between a write-clock writer and a read-clock reader
`timescale 1ns/1ps
module dcff_top (
  input wire logic clk, // system clock, 40 MHz
  input wire logic resetn, // asynchronous reset, active low
  input wire logic wrClk, // writer's clock pin, sampled
  input wire logic wrEn1N, // first write enable, active low
  input wire logic wrEn2Load, // second write enable or load strobe
  input wire logic [8:0] dataIn, // write data pins
  input wire logic rdClk, // reader's clock pin, sampled
  input wire logic rdEn1N, // first read enable, active low
  input wire logic rdEn2N, // second read enable, active low
  input wire logic outDriveN, // output drive enable pin, active low
  output logic [8:0] dataOut, // read data
  output logic dataOutOeN, // low while dataOut drives the pins
  output logic emptyIndicatorN, // low when buffer is empty
  output logic almostEmptyIndicatorN, // low at or below the low watermark
  output logic fullIndicatorN, // low when buffer is full
  output logic almostFullIndicatorN // low at or above the high watermark
);

  localparam int AW = dcff_pkg::ADDR_W;
  localparam int PW = dcff_pkg::PTR_W;
  localparam int DW = dcff_pkg::DATA_W;

  dcff_pkg::dcff_pins_s pinRaw;
  dcff_pkg::dcff_pins_s pinSync;
  logic [dcff_pkg::PINS_W-1:0] syncBits;

  // every input but clk and resetn, link clocks included, passes the same two flops so data and edges align
  assign pinRaw = '{
    wrClk: wrClk,
    rdClk: rdClk,
    wrEn1N: wrEn1N,
    wrEn2Load: wrEn2Load,
    rdEn1N: rdEn1N,
    rdEn2N: rdEn2N,
    outDriveN: outDriveN,
    data: dataIn
  };

  dcff_sync #(
    .W(dcff_pkg::PINS_W)
  ) pinSyncer (
    .clk(clk),
    .din(pinRaw),
    .dout(syncBits)
  );

  assign pinSync = dcff_pkg::dcff_pins_s'(syncBits);

  // clock edge detection on the synchronised clock levels
  logic wrClkPrev;
  logic rdClkPrev;
  logic wrEdge;
  logic rdEdge;

  // link clocks are only sampled, so they may run on freely through reset
  // [RULE_04] free clocks tolerated
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrClkPrev <= 1'b0;
      rdClkPrev <= 1'b0;
    end else begin
      wrClkPrev <= pinSync.wrClk;
      rdClkPrev <= pinSync.rdClk;
    end
  end

  assign wrEdge = pinSync.wrClk & ~wrClkPrev;
  assign rdEdge = pinSync.rdClk & ~rdClkPrev;

  // strap capture: second enable or load strobe
  logic strapTaken;
  logic loadMode;
  logic next_strapTaken;
  logic next_loadMode;

  // the synchroniser has no reset, so its output on the first cycle after release
  // still shows the level held during reset
  // [RULE_06] strap selects role
  always_comb begin
    next_strapTaken = 1'b1;
    next_loadMode = loadMode;
    if (!strapTaken) begin
      next_loadMode = ~pinSync.wrEn2Load;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strapTaken <= 1'b0;
      loadMode <= 1'b0;
    end else begin
      strapTaken <= next_strapTaken;
      loadMode <= next_loadMode;
    end
  end

  // request qualification
  logic doWrite;
  logic doLoad;
  logic doRead;

  // a write needs both enables in either role; a load is the strobe low in load role
  // [RULE_11] refuse when full
  assign doWrite = wrEdge & strapTaken & ~pinSync.wrEn1N & pinSync.wrEn2Load
                   & fullIndicatorN;
  assign doLoad = wrEdge & strapTaken & loadMode & ~pinSync.wrEn1N & ~pinSync.wrEn2Load;
  // [RULE_11] refuse when empty
  assign doRead = rdEdge & strapTaken & ~pinSync.rdEn1N & ~pinSync.rdEn2N & emptyIndicatorN;

  // offset registers and their load sequence
  logic [dcff_pkg::OFS_W-1:0] aeOffset;
  logic [dcff_pkg::OFS_W-1:0] afOffset;
  logic [dcff_pkg::OFS_W-1:0] next_aeOffset;
  logic [dcff_pkg::OFS_W-1:0] next_afOffset;
  dcff_pkg::dcff_load_e loadStep;
  dcff_pkg::dcff_load_e next_loadStep;

  // each strobe fills the next half-register, low part then high part
  always_comb begin
    next_aeOffset = aeOffset;
    next_afOffset = afOffset;
    next_loadStep = loadStep;
    if (doLoad) begin
      case (loadStep)
        dcff_pkg::LOAD_AE_LO: begin
          next_aeOffset[dcff_pkg::OFS_LO_W-1:0] = pinSync.data;
          next_loadStep = dcff_pkg::LOAD_AE_HI;
        end
        dcff_pkg::LOAD_AE_HI: begin
          next_aeOffset[dcff_pkg::OFS_W-1:dcff_pkg::OFS_LO_W] =
            pinSync.data[dcff_pkg::OFS_HI_W-1:0];
          next_loadStep = dcff_pkg::LOAD_AF_LO;
        end
        dcff_pkg::LOAD_AF_LO: begin
          next_afOffset[dcff_pkg::OFS_LO_W-1:0] = pinSync.data;
          next_loadStep = dcff_pkg::LOAD_AF_HI;
        end
        default: begin
          next_afOffset[dcff_pkg::OFS_W-1:dcff_pkg::OFS_LO_W] =
            pinSync.data[dcff_pkg::OFS_HI_W-1:0];
          next_loadStep = dcff_pkg::LOAD_AE_LO;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aeOffset <= dcff_pkg::OFS_DEFAULT;
      afOffset <= dcff_pkg::OFS_DEFAULT;
      loadStep <= dcff_pkg::LOAD_AE_LO;
    end else begin
      aeOffset <= next_aeOffset;
      afOffset <= next_afOffset;
      loadStep <= next_loadStep;
    end
  end

  // storage and pointers
  logic [DW-1:0] mem [2**AW];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [PW-1:0] next_wrPtr;
  logic [PW-1:0] next_rdPtr;

  // storage needs no reset; only the pointers say what is valid
  always_ff @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr[AW-1:0]] <= pinSync.data;
    end
  end

  assign next_wrPtr = wrPtr + PW'(doWrite);
  assign next_rdPtr = rdPtr + PW'(doRead);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
    end
  end

  // far-side pointers settled over the two skew minimums
  logic [PW-1:0] wrSeenSkew1;
  logic [PW-1:0] wrSeenSkew2;
  logic [PW-1:0] rdSeenSkew1;
  logic [PW-1:0] rdSeenSkew2;

  // a move closer to the edge than the skew is not yet in the copy, so the flag
  // slips one edge instead of acting on a half-seen pointer
  // [RULE_02] empty sees skew-one write pointer
  dcff_settle #(
    .CNT(dcff_pkg::SKEW1_CNT)
  ) wrSettle1 (
    .clk(clk),
    .resetn(resetn),
    .moved(doWrite),
    .ptr(wrPtr),
    .settled(wrSeenSkew1)
  );

  // [RULE_03] almost-empty uses skew two
  dcff_settle #(
    .CNT(dcff_pkg::SKEW2_CNT)
  ) wrSettle2 (
    .clk(clk),
    .resetn(resetn),
    .moved(doWrite),
    .ptr(wrPtr),
    .settled(wrSeenSkew2)
  );

  // [RULE_01] full sees skew-one read pointer
  dcff_settle #(
    .CNT(dcff_pkg::SKEW1_CNT)
  ) rdSettle1 (
    .clk(clk),
    .resetn(resetn),
    .moved(doRead),
    .ptr(rdPtr),
    .settled(rdSeenSkew1)
  );

  dcff_settle #(
    .CNT(dcff_pkg::SKEW2_CNT)
  ) rdSettle2 (
    .clk(clk),
    .resetn(resetn),
    .moved(doRead),
    .ptr(rdPtr),
    .settled(rdSeenSkew2)
  );

  // flag evaluation
  dcff_pkg::dcff_flags_s flags;
  dcff_pkg::dcff_flags_s next_flags;
  logic [PW-1:0] rdCount1;
  logic [PW-1:0] rdCount2;
  logic [PW-1:0] wrCount1;
  logic [PW-1:0] wrCount2;
  logic [PW-1:0] afLimit;

  assign rdCount1 = wrSeenSkew1 - next_rdPtr;
  assign rdCount2 = wrSeenSkew2 - next_rdPtr;
  assign wrCount1 = next_wrPtr - rdSeenSkew1;
  assign wrCount2 = next_wrPtr - rdSeenSkew2;
  // almost-full threshold is full minus (offset - 1)
  assign afLimit = dcff_pkg::FULL_COUNT - PW'(afOffset) + PW'(1);

  // read-side flags move only on read edges, write-side flags only on write edges
  always_comb begin
    next_flags = flags;
    // [RULE_12] read edge updates
    if (rdEdge) begin
      // [RULE_08] boundary latency via settle
      next_flags.emptyN = (rdCount1 != '0);
      // [RULE_09] low below offset
      next_flags.almostEmptyN = (rdCount2 >= PW'(aeOffset));
    end
    // [RULE_12] write edge updates
    if (wrEdge) begin
      next_flags.fullN = (wrCount1 != dcff_pkg::FULL_COUNT);
      // [RULE_10] low at full minus offset-one
      next_flags.almostFullN = (wrCount2 < afLimit);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags.emptyN <= dcff_pkg::FLAG_ASSERTED;
      flags.almostEmptyN <= dcff_pkg::FLAG_ASSERTED;
      flags.fullN <= dcff_pkg::FLAG_RELEASED;
      flags.almostFullN <= dcff_pkg::FLAG_RELEASED;
    end else begin
      flags <= next_flags;
    end
  end

  assign emptyIndicatorN = flags.emptyN;
  assign almostEmptyIndicatorN = flags.almostEmptyN;
  assign fullIndicatorN = flags.fullN;
  assign almostFullIndicatorN = flags.almostFullN;

  // read data and output drive
  logic [DW-1:0] next_dataOut;
  logic next_dataOutOeN;

  // the first word can only be taken once empty has released, so it appears one
  // read edge after that release at the earliest
  // [RULE_07] first word after release
  always_comb begin
    next_dataOut = dataOut;
    if (doRead) begin
      next_dataOut = mem[rdPtr[AW-1:0]];
    end
    next_dataOutOeN = pinSync.outDriveN;
  end

  // data resets low and drive resets released; after reset the drive follows the pin
  // [RULE_05] low or released
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dataOut <= dcff_pkg::DATA_RESET;
      dataOutOeN <= 1'b1;
    end else begin
      dataOut <= next_dataOut;
      dataOutOeN <= next_dataOutOeN;
    end
  end

endmodule

// ===== dcff_top_asserts.sv
// concurrent checks on the buffer's pins
`timescale 1ns/1ps
module dcff_top_asserts (
  input wire logic clk, // system clock
  input wire logic resetn, // reset, active low
  input wire logic wrClk, // writer clock
  input wire logic wrEn1N, // write enable one
  input wire logic wrEn2Load, // enable two or load
  input wire logic [8:0] dataIn, // write data
  input wire logic rdClk, // reader clock
  input wire logic rdEn1N, // read enable one
  input wire logic rdEn2N, // read enable two
  input wire logic outDriveN, // drive enable
  input wire logic [8:0] dataOut, // read data
  input wire logic dataOutOeN, // low while driving
  input wire logic emptyIndicatorN, // empty flag
  input wire logic almostEmptyIndicatorN, // almost-empty flag
  input wire logic fullIndicatorN, // full flag
  input wire logic almostFullIndicatorN // almost-full flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // idle state and output drive
  a_reset_state: assert property ($rose(resetn) |-> dataOut == 9'h000 &&
    !emptyIndicatorN && !almostEmptyIndicatorN && fullIndicatorN && almostFullIndicatorN)
    else $error("outputs not idle after reset");
  a_drive_on: assert property ($fell(outDriveN) |-> ##[1:4] !dataOutOeN)
    else $error("data pins not driven");
  a_drive_off: assert property ($rose(outDriveN) |-> ##[1:4] dataOutOeN)
    else $error("data pins not released");

  // reads only when asked and not empty
  a_hold_empty: assert property (!emptyIndicatorN |=> $stable(dataOut))
    else $error("data changed while empty");
  a_read_cause: assert property (!$stable(dataOut) |->
    !$past(rdEn1N, 3) && !$past(rdEn2N, 3))
    else $error("data changed without read enables");
  a_first_word: assert property ($rose(emptyIndicatorN) && !rdEn1N && !rdEn2N |->
    $stable(dataOut) [*7] ##[1:3] !$stable(dataOut))
    else $error("first word not on following read edge");

  // empty and almost-empty rise, and almost-full falls, only just after their own side's clock rose; almost-empty is low whenever empty is
  a_empty_on_rd: assert property ($rose(emptyIndicatorN) |->
    $past(rdClk, 2) && !$past(rdClk, 6))
    else $error("empty released off a read edge");
  a_aempty_on_rd: assert property ($rose(almostEmptyIndicatorN) |->
    $past(rdClk, 2) && !$past(rdClk, 6))
    else $error("almost-empty moved off a read edge");
  a_afull_on_wr: assert property ($fell(almostFullIndicatorN) |->
    $past(wrClk, 2) && !$past(wrClk, 6))
    else $error("almost-full moved off a write edge");
  a_ae_with_empty: assert property (!emptyIndicatorN |-> !almostEmptyIndicatorN)
    else $error("almost-empty high while empty");
endmodule

// ===== dcff_top_bench.sv
// self-checking bench for the dual-clock buffer
`timescale 1ns/1ps
module dcff_top_bench;
  logic clk, resetn, outDriveN, wrClk, rdClk, wrEn1N, wrEn2Load, rdEn1N, rdEn2N;
  logic dataOutOeN, emptyN, almostEmptyN, fullN, almostFullN;
  logic [8:0] dataIn, dataOut, d;
  logic [3:0] flags;
  logic [8:0] ofs [4] = '{9'h003, 9'h000, 9'h1FF, 9'h01F};
  int errors = 0;
  int samplesChecked = 0;
  int cycles = 0;
  int n, hi;
  assign flags = {emptyN, almostEmptyN, fullN, almostFullN};

  dcff_top uut (.clk(clk), .resetn(resetn), .wrClk(wrClk), .wrEn1N(wrEn1N),
    .wrEn2Load(wrEn2Load), .dataIn(dataIn), .rdClk(rdClk), .rdEn1N(rdEn1N),
    .rdEn2N(rdEn2N), .outDriveN(outDriveN), .dataOut(dataOut), .dataOutOeN(dataOutOeN),
    .emptyIndicatorN(emptyN), .almostEmptyIndicatorN(almostEmptyN),
    .fullIndicatorN(fullN), .almostFullIndicatorN(almostFullN));
  dcff_link_model link (.clk(clk), .dataOut(dataOut), .wrClk(wrClk), .rdClk(rdClk),
    .wrEn1N(wrEn1N), .wrEn2Load(wrEn2Load), .dataIn(dataIn), .rdEn1N(rdEn1N),
    .rdEn2N(rdEn2N));

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  // hang guard: far above the thousand or so cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // long enough for both sides' flags to settle
  task automatic settle();
    repeat (40) @(negedge clk);
  endtask
  task automatic end_of_test();
    if (errors == 0 && samplesChecked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    resetn = 1'b0;
    outDriveN = 1'b1;
    repeat (2) @(negedge clk);
    check("flags", {5'h00, flags}, 9'h003);
    check("oe", {8'h00, dataOutOeN}, 9'h001);
    resetn = 1'b1;
    @(negedge clk);
    outDriveN = 1'b0;
    repeat (5) @(negedge clk);
    check("oe", {8'h00, dataOutOeN}, 9'h000);
    check("dataOut", dataOut, 9'h000);
    link.pop(d);
    check("refused read", d, 9'h000);
    // fill past the default low watermark, then drain
    for (int i = 1; i <= 7; i++) begin
      link.push(9'h0A0 + 9'(i), 1'h0);
      settle();
      check("flags", {5'h00, flags}, {5'h00, 1'h1, (i >= 7), 2'h3});
    end
    // below the low watermark after every read, so almost-empty stays low
    for (int i = 1; i <= 7; i++) begin
      link.pop(d);
      check("dataOut", d, 9'h0A0 + 9'(i));
      settle();
      check("flags", {5'h00, flags}, {5'h00, (i < 7), 1'h0, 2'h3});
    end
    // first word across the empty boundary with reads pending
    @(negedge clk);
    link.holdRead(1'h1);
    link.push(9'h15A, 1'h0);
    n = 0;
    hi = 0;
    while (dataOut !== 9'h15A && n < 60) begin
      if (emptyN === 1'b1) hi++;
      @(negedge clk);
      n++;
    end
    check("word gap", 9'(hi), 9'h008);
    check("latency", {8'h00, n <= 40}, 9'h001);
    link.holdRead(1'h0);
    // let the first-word checks finish before the next reset wipes the output
    repeat (4) @(negedge clk);
    check("first word", dataOut, 9'h15A);
    // second reset with the strap low selects the offset load role
    resetn = 1'b0;
    link.setStrap(1'h0);
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    link.setStrap(1'h1);
    check("dataOut", dataOut, 9'h000);
    foreach (ofs[k]) link.push(ofs[k], 1'h1);
    for (int i = 1; i <= 3; i++) begin
      link.push(9'h0C0 + 9'(i), 1'h0);
      settle();
      check("flags", {5'h00, flags}, {5'h00, 1'h1, (i >= 3), 1'h1, (i < 2)});
    end
    outDriveN = 1'b1;
    repeat (5) @(negedge clk);
    check("oe", {8'h00, dataOutOeN}, 9'h001);
    end_of_test();
  end
endmodule

bind dcff_top dcff_top_asserts chk (.clk(clk), .resetn(resetn), .wrClk(wrClk),
  .wrEn1N(wrEn1N), .wrEn2Load(wrEn2Load), .dataIn(dataIn), .rdClk(rdClk),
  .rdEn1N(rdEn1N), .rdEn2N(rdEn2N), .outDriveN(outDriveN), .dataOut(dataOut),
  .dataOutOeN(dataOutOeN), .emptyIndicatorN(emptyIndicatorN),
  .almostEmptyIndicatorN(almostEmptyIndicatorN), .fullIndicatorN(fullIndicatorN),
  .almostFullIndicatorN(almostFullIndicatorN));
